// ==== common/cpsd_pkg.sv ====
// constants and types shared by the control-port strap decoder
package cpsd_pkg;

  // bus-select strap codes
  localparam logic [1:0] BIS_MUXED  = 2'h0;
  localparam logic [1:0] BIS_NONMUX = 2'h1;
  localparam logic [1:0] BIS_SERIAL = 2'h2;
  localparam logic [1:0] BIS_HW     = 2'h3;

  typedef enum logic [3:0] {
    CPSD_MODE_MUXED  = 4'h1,
    CPSD_MODE_NONMUX = 4'h2,
    CPSD_MODE_SERIAL = 4'h4,
    CPSD_MODE_HW     = 4'h8
  } cpsd_mode_e;

  // transmit clock source codes, high strap in bit 1
  localparam logic [1:0] TCS_EXT  = 2'h0;
  localparam logic [1:0] TCS_PLL  = 2'h1;
  localparam logic [1:0] TCS_MCLK = 2'h2;
  localparam logic [1:0] TCS_RCLK = 2'h3;

  // path mode codes used to recognise T1 and E1 operation
  localparam logic [1:0] RX_MODE_T1 = 2'h0;
  localparam logic [1:0] RX_MODE_E1 = 2'h1;
  localparam logic       TX_MODE_T1 = 1'b0;
  localparam logic       TX_MODE_E1 = 1'b1;

  // build-out codes that select the payload clock variant
  localparam logic [2:0] BO_PAYLOAD_A = 3'h6;
  localparam logic [2:0] BO_PAYLOAD_B = 3'h7;

  // register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STRAPS = 8'h08;

  // control register fields
  localparam int          CTRL_PLL_REF_EXT = 0;
  localparam int          CTRL_TCS         = 1;
  localparam int          CTRL_PLL_OUT_MUX = 3;
  localparam int          CTRL_PAYLOAD_EN  = 4;
  localparam int          CTRL_TX_TERM_EN  = 5;
  localparam int          CTRL_RX_TERM_EN  = 6;
  localparam int          CTRL_TERM_120    = 7;
  localparam int          CTRL_RX_MODE     = 8;
  localparam int          CTRL_TX_MODE     = 10;
  localparam int          CTRL_WIDTH       = 11;
  localparam logic [10:0] CTRL_RESET       = 11'h000;

  // status register fields
  localparam int STAT_MODE       = 0;
  localparam int STAT_ALT_TIMING = 4;
  localparam int STAT_TX_PAYLOAD = 5;
  localparam int STAT_RX_PAYLOAD = 6;
  localparam int STAT_TX_TERM    = 7;
  localparam int STAT_RX_TERM    = 8;
  localparam int STAT_TCS        = 9;

  // strap snapshot register fields
  localparam int STRAP_ADDR = 0;
  localparam int STRAP_AD   = 8;
  localparam int STRAP_BIS  = 16;

endpackage

// ==== core/cpsd_sync.sv ====
// two-flop synchroniser for a bundle of pin-level inputs
`timescale 1ns/10ps
module cpsd_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // stage1 is read only by the second flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// ==== core/cpsd_clk_mux.sv ====
// transmit clock source mux, pll output routing and payload gapping
`timescale 1ns/10ps
module cpsd_clk_mux (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ext_clk,
  input  wire logic       pll_clk,
  input  wire logic       mclk_scaled,
  input  wire logic       rec_clk,
  input  wire logic [1:0] tcs,
  input  wire logic       pll_out_from_mux,
  input  wire logic       tx_payload,
  input  wire logic       rx_payload,
  input  wire logic       tx_gap_slot,
  input  wire logic       rx_gap_slot,
  output logic            tx_clock_out_pin,
  output logic            pll_out_pin,
  output logic            rx_clock_out
);

  logic tx_sel;

  always_comb begin
    unique case (tcs)
      cpsd_pkg::TCS_EXT:  tx_sel = ext_clk;
      cpsd_pkg::TCS_PLL:  tx_sel = pll_clk;
      cpsd_pkg::TCS_MCLK: tx_sel = mclk_scaled;
      cpsd_pkg::TCS_RCLK: tx_sel = rec_clk;
    endcase
  end

  // pulses in the framing slot are dropped only while the payload clock is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_clock_out_pin <= 1'b0;
      rx_clock_out     <= 1'b0;
    end else begin
      tx_clock_out_pin <= tx_sel & ~(tx_payload & tx_gap_slot);   // RL16
      rx_clock_out     <= rec_clk & ~(rx_payload & rx_gap_slot);  // RL16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_out_pin <= 1'b0;
    end else begin
      pll_out_pin <= pll_out_from_mux ? tx_sel : pll_clk;  // RL13
    end
  end

endmodule

// ==== core/cpsd_top.sv ====
// control-port strap decoder: bus personality, pin routing and hardware-mode straps
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// How it works
// [RL1] select 01 nonmuxed parallel, 00 multiplexed parallel
// [RL2] select 10 gives serial slave port
// [RL3] select 11 is hardware mode, no registers
// [RL4] timing strap picks first or second style
// [RL5] hardware mode repurposes pins, others stay fixed
// [RL6] serial clock, phase, polarity on given pins
// [RL7] far side grounds unused pins in serial
// [RL8] address pins give build-out, tx mode, alarm force
// [RL9] address pins prescaler, data pins rx mode
// [RL10] data pins 6, 7 disable terminations
// [RL11] hardware mode: pll reference always external clock
// [RL12] two straps choose one of four tx clocks
// [RL13] pll output pin equals selected tx clock
// [RL14] termination follows mode, each side disable strap
// [RL15] e1 strap picks 75 or 120 ohm
// [RL16] payload clock gaps framing slot pulses
// [RL17] gapping only in t1 or e1 modes
// [RL18] hardware payload clock via build-out codes
// [RL19] alarm outputs live in every mode
module cpsd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  bus_interface_select,
  input  wire logic        bus_timing_style_select,
  input  wire logic        tx_clock_source_sel_lo,
  input  wire logic        tx_clock_source_sel_hi,
  input  wire logic [7:0]  ad_in,
  output logic      [7:0]  ad_out,
  output logic             ad_oe,
  input  wire logic [7:0]  addr_in,
  input  wire logic        external_tx_clock_in,
  input  wire logic        tx_pll_clk,
  input  wire logic        scaled_mclk,
  input  wire logic        recovered_clk,
  input  wire logic [7:0]  port_rd_data,
  input  wire logic        port_rd_drive,
  input  wire logic        tx_gap_slot,
  input  wire logic        rx_gap_slot,
  input  wire logic        alarm_los_in,
  input  wire logic        alarm_ais_in,
  input  wire logic        alarm_lof_in,
  output logic             mode_muxed,
  output logic             mode_nonmux,
  output logic             mode_serial,
  output logic             mode_hw,
  output logic             alt_timing_style,
  output logic             address_latch_strobe,
  output logic      [7:0]  par_addr,
  output logic      [7:0]  par_ad,
  output logic             serial_sck,
  output logic             serial_cpha,
  output logic             serial_cpol,
  output logic      [2:0]  build_out_sel,
  output logic             tx_path_mode_sel_0,
  output logic             tx_alarm_signal_force,
  output logic      [1:0]  prescaler_sel,
  output logic      [1:0]  rx_path_mode_sel,
  output logic             tx_termination_disable,
  output logic             rx_termination_disable,
  output logic             e1_termination_select,
  output logic             pll_ref_from_ext,
  output logic             tx_term_on,
  output logic             rx_term_on,
  output logic             tx_term_120,
  output logic             rx_term_120,
  output logic             tx_payload_active,
  output logic             rx_payload_active,
  output logic             tx_clock_out_pin,
  output logic             pll_out_pin,
  output logic             rx_clock_out,
  output logic             alarm_los,
  output logic             alarm_ais,
  output logic             alarm_lof
);

  logic [1:0]            bis_s;
  logic                  bts_s;
  logic [1:0]            tcss_s;
  logic [7:0]            ad_s;
  logic [7:0]            addr_s;
  logic [3:0]            clk_s;
  cpsd_pkg::cpsd_mode_e  mode;
  cpsd_pkg::cpsd_mode_e  next_mode;
  logic [10:0]           ctrl;
  logic                  hw;
  logic                  parallel;
  logic [1:0]            eff_tcs;
  logic                  eff_pll_mux;
  logic [1:0]            eff_rx_mode;
  logic                  eff_tx_mode;
  logic                  rx_framed;
  logic                  tx_framed;
  logic                  payload_req;
  logic                  next_tx_term;
  logic                  next_rx_term;
  logic                  term_120_sel;
  logic                  access;
  logic                  mapped;
  logic                  refuse;

  // strap, ad and address pins and foreign clocks are two-flop synchronised first; port read data, gap slots and alarms are not
  cpsd_sync #(
    .WIDTH (25)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({bus_interface_select, bus_timing_style_select, tx_clock_source_sel_hi,
                tx_clock_source_sel_lo, ad_in, addr_in, external_tx_clock_in, tx_pll_clk,
                scaled_mclk, recovered_clk}),
    .sync_out ({bis_s, bts_s, tcss_s, ad_s, addr_s, clk_s})
  );

  always_comb begin
    unique case (bis_s)
      cpsd_pkg::BIS_MUXED:  next_mode = cpsd_pkg::CPSD_MODE_MUXED;   // RL1
      cpsd_pkg::BIS_NONMUX: next_mode = cpsd_pkg::CPSD_MODE_NONMUX;  // RL1
      cpsd_pkg::BIS_SERIAL: next_mode = cpsd_pkg::CPSD_MODE_SERIAL;  // RL2
      cpsd_pkg::BIS_HW:     next_mode = cpsd_pkg::CPSD_MODE_HW;      // RL3
    endcase
  end

  // straps are static, but follow them so a board change needs no reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= cpsd_pkg::CPSD_MODE_MUXED;
    end else begin
      mode <= next_mode;
    end
  end

  assign hw       = (mode == cpsd_pkg::CPSD_MODE_HW);
  assign parallel = (mode == cpsd_pkg::CPSD_MODE_MUXED) || (mode == cpsd_pkg::CPSD_MODE_NONMUX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_muxed       <= 1'b1;
      mode_nonmux      <= 1'b0;
      mode_serial      <= 1'b0;
      mode_hw          <= 1'b0;
      alt_timing_style <= 1'b0;
    end else begin
      mode_muxed       <= (mode == cpsd_pkg::CPSD_MODE_MUXED);   // RL1
      mode_nonmux      <= (mode == cpsd_pkg::CPSD_MODE_NONMUX);  // RL1
      mode_serial      <= (mode == cpsd_pkg::CPSD_MODE_SERIAL);  // RL2
      mode_hw          <= hw;                                    // RL3
      alt_timing_style <= parallel & bts_s;                      // RL4
    end
  end

  // parallel and serial routing; in serial mode only three pins are looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_addr             <= 8'h00;
      par_ad               <= 8'h00;
      address_latch_strobe <= 1'b0;
      serial_sck           <= 1'b0;
      serial_cpha          <= 1'b0;
      serial_cpol          <= 1'b0;
      ad_out               <= 8'h00;
      ad_oe                <= 1'b0;
    end else begin
      par_addr             <= parallel ? addr_s : 8'h00;
      par_ad               <= parallel ? ad_s : 8'h00;
      address_latch_strobe <= (mode == cpsd_pkg::CPSD_MODE_MUXED) & addr_s[7];
      serial_sck           <= mode_is_serial() & ad_s[2];    // RL6
      serial_cpha          <= mode_is_serial() & addr_s[4];  // RL6
      serial_cpol          <= mode_is_serial() & addr_s[5];  // RL6
      ad_out               <= port_rd_data;
      ad_oe                <= parallel & port_rd_drive;      // RL5
    end
  end

  function automatic logic mode_is_serial();
    return mode == cpsd_pkg::CPSD_MODE_SERIAL;
  endfunction

  // strap fields are only live in hardware mode, fixed at zero otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      build_out_sel          <= 3'h0;
      tx_path_mode_sel_0     <= 1'b0;
      tx_alarm_signal_force  <= 1'b0;
      prescaler_sel          <= 2'h0;
      rx_path_mode_sel       <= 2'h0;
      tx_termination_disable <= 1'b0;
      rx_termination_disable <= 1'b0;
      e1_termination_select  <= 1'b0;
    end else begin
      build_out_sel          <= hw ? addr_s[4:2] : 3'h0;  // RL8 RL5
      tx_path_mode_sel_0     <= hw & addr_s[5];           // RL8
      tx_alarm_signal_force  <= hw & addr_s[1];           // RL8
      prescaler_sel          <= hw ? addr_s[7:6] : 2'h0;  // RL9
      rx_path_mode_sel       <= hw ? ad_s[5:4] : 2'h0;    // RL9
      tx_termination_disable <= hw & ad_s[6];             // RL10
      rx_termination_disable <= hw & ad_s[7];             // RL10
      e1_termination_select  <= hw & addr_s[0];
    end
  end

  // effective configuration: straps in hardware mode (pll output mux forced on there), control register otherwise
  assign eff_tcs     = hw ? tcss_s : ctrl[cpsd_pkg::CTRL_TCS +: 2];   // RL12
  assign eff_pll_mux = hw | ctrl[cpsd_pkg::CTRL_PLL_OUT_MUX];         // RL13
  assign eff_rx_mode = hw ? ad_s[5:4] : ctrl[cpsd_pkg::CTRL_RX_MODE +: 2];
  assign eff_tx_mode = hw ? addr_s[5] : ctrl[cpsd_pkg::CTRL_TX_MODE];
  assign rx_framed   = (eff_rx_mode == cpsd_pkg::RX_MODE_T1) ||
                       (eff_rx_mode == cpsd_pkg::RX_MODE_E1);          // RL17
  assign tx_framed   = (eff_tx_mode == cpsd_pkg::TX_MODE_T1) ||
                       (eff_tx_mode == cpsd_pkg::TX_MODE_E1);          // RL17
  assign payload_req = hw ? ((addr_s[4:2] == cpsd_pkg::BO_PAYLOAD_A) ||
                             (addr_s[4:2] == cpsd_pkg::BO_PAYLOAD_B))
                          : ctrl[cpsd_pkg::CTRL_PAYLOAD_EN];           // RL18
  assign next_tx_term = hw ? (tx_framed & ~ad_s[6]) : ctrl[cpsd_pkg::CTRL_TX_TERM_EN];  // RL14
  assign next_rx_term = hw ? (rx_framed & ~ad_s[7]) : ctrl[cpsd_pkg::CTRL_RX_TERM_EN];  // RL14
  assign term_120_sel = hw ? addr_s[0] : ctrl[cpsd_pkg::CTRL_TERM_120];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ref_from_ext  <= 1'b0;
      tx_term_on        <= 1'b0;
      rx_term_on        <= 1'b0;
      tx_term_120       <= 1'b0;
      rx_term_120       <= 1'b0;
      tx_payload_active <= 1'b0;
      rx_payload_active <= 1'b0;
    end else begin
      pll_ref_from_ext  <= hw | ctrl[cpsd_pkg::CTRL_PLL_REF_EXT];  // RL11
      tx_term_on        <= next_tx_term;                           // RL14
      rx_term_on        <= next_rx_term;                           // RL14
      // one selector drives both directions, and only in e1
      tx_term_120       <= next_tx_term & (eff_tx_mode == cpsd_pkg::TX_MODE_E1)
                           & term_120_sel;                         // RL15
      rx_term_120       <= next_rx_term & (eff_rx_mode == cpsd_pkg::RX_MODE_E1)
                           & term_120_sel;                         // RL15
      tx_payload_active <= payload_req & tx_framed;                // RL16 RL17
      rx_payload_active <= payload_req & rx_framed;                // RL16 RL17
    end
  end

  cpsd_clk_mux u_clk_mux (
    .pclk             (pclk),
    .presetn          (presetn),
    .ext_clk          (clk_s[3]),
    .pll_clk          (clk_s[2]),
    .mclk_scaled      (clk_s[1]),
    .rec_clk          (clk_s[0]),
    .tcs              (eff_tcs),
    .pll_out_from_mux (eff_pll_mux),
    .tx_payload       (tx_payload_active),
    .rx_payload       (rx_payload_active),
    .tx_gap_slot      (tx_gap_slot),
    .rx_gap_slot      (rx_gap_slot),
    .tx_clock_out_pin (tx_clock_out_pin),
    .pll_out_pin      (pll_out_pin),
    .rx_clock_out     (rx_clock_out)
  );

  // alarms bypass every mode decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_los <= 1'b0;
      alarm_ais <= 1'b0;
      alarm_lof <= 1'b0;
    end else begin
      alarm_los <= alarm_los_in;  // RL19
      alarm_ais <= alarm_ais_in;  // RL19
      alarm_lof <= alarm_lof_in;  // RL19
    end
  end

  // apb slave: zero wait states, read data captured in the setup cycle
  assign access  = psel & penable;
  assign mapped  = (paddr == cpsd_pkg::REG_CTRL) || (paddr == cpsd_pkg::REG_STATUS) ||
                   (paddr == cpsd_pkg::REG_STRAPS);
  assign refuse  = hw | ~mapped;  // RL3
  assign pready  = 1'b1;
  assign pslverr = access & refuse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= cpsd_pkg::CTRL_RESET;
    end else if (access && pwrite && !refuse && paddr == cpsd_pkg::REG_CTRL) begin
      ctrl <= pwdata[cpsd_pkg::CTRL_WIDTH-1:0];  // RL3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (!hw) begin
        unique case (paddr)
          cpsd_pkg::REG_CTRL: begin
            prdata[cpsd_pkg::CTRL_WIDTH-1:0] <= ctrl;
          end
          cpsd_pkg::REG_STATUS: begin
            prdata[cpsd_pkg::STAT_MODE +: 4]     <= mode;
            prdata[cpsd_pkg::STAT_ALT_TIMING]    <= alt_timing_style;
            prdata[cpsd_pkg::STAT_TX_PAYLOAD]    <= tx_payload_active;
            prdata[cpsd_pkg::STAT_RX_PAYLOAD]    <= rx_payload_active;
            prdata[cpsd_pkg::STAT_TX_TERM]       <= tx_term_on;
            prdata[cpsd_pkg::STAT_RX_TERM]       <= rx_term_on;
            prdata[cpsd_pkg::STAT_TCS +: 2]      <= eff_tcs;
          end
          cpsd_pkg::REG_STRAPS: begin
            prdata[cpsd_pkg::STRAP_ADDR +: 8]    <= addr_s;
            prdata[cpsd_pkg::STRAP_AD +: 8]      <= ad_s;
            prdata[cpsd_pkg::STRAP_BIS +: 2]     <= bis_s;
          end
          default: begin
          end
        endcase
      end
    end
  end

  a_mode_nonmux: assert property (@(posedge pclk) disable iff (!presetn)  // RL1
    bis_s == cpsd_pkg::BIS_NONMUX |=> ##1 mode_nonmux && !mode_muxed)
    else $error("nonmux select not decoded");
  a_mode_serial: assert property (@(posedge pclk) disable iff (!presetn)  // RL2
    bis_s == cpsd_pkg::BIS_SERIAL |=> ##1 mode_serial && !mode_hw)
    else $error("serial select not decoded");
  a_hw_refuse: assert property (@(posedge pclk) disable iff (!presetn)  // RL3
    hw && access && pwrite |-> pslverr ##1 $stable(ctrl))
    else $error("register write taken in hardware mode");
  a_timing_style: assert property (@(posedge pclk) disable iff (!presetn)  // RL4
    parallel |=> alt_timing_style == $past(bts_s))
    else $error("timing style does not follow strap");
  a_fixed_fields: assert property (@(posedge pclk) disable iff (!presetn)  // RL5
    !hw |=> build_out_sel == 3'h0 && prescaler_sel == 2'h0 && !tx_alarm_signal_force)
    else $error("strap field live outside hardware mode");
  a_serial_pins: assert property (@(posedge pclk) disable iff (!presetn)  // RL6
    mode == cpsd_pkg::CPSD_MODE_SERIAL |=>
      serial_sck == $past(ad_s[2]) && serial_cpol == $past(addr_s[5]))
    else $error("serial clock or polarity misrouted");
  a_build_out: assert property (@(posedge pclk) disable iff (!presetn)  // RL8
    hw |=> build_out_sel == $past(addr_s[4:2]) && tx_path_mode_sel_0 == $past(addr_s[5]))
    else $error("build-out or tx mode strap misrouted");
  a_prescaler: assert property (@(posedge pclk) disable iff (!presetn)  // RL9
    hw |=> prescaler_sel == $past(addr_s[7:6]) && rx_path_mode_sel == $past(ad_s[5:4]))
    else $error("prescaler or rx mode strap misrouted");
  a_term_disable: assert property (@(posedge pclk) disable iff (!presetn)  // RL10
    hw && ad_s[6] |=> tx_termination_disable && !tx_term_on)
    else $error("tx termination not disabled");
  a_pll_ref: assert property (@(posedge pclk) disable iff (!presetn)  // RL11
    hw |=> pll_ref_from_ext)
    else $error("pll reference not external in hardware mode");
  a_payload_bo: assert property (@(posedge pclk) disable iff (!presetn)  // RL18
    hw && addr_s[4:2] != cpsd_pkg::BO_PAYLOAD_A && addr_s[4:2] != cpsd_pkg::BO_PAYLOAD_B
      |=> !tx_payload_active && !rx_payload_active)
    else $error("payload clock on without payload build-out");
  a_alarm_pass: assert property (@(posedge pclk) disable iff (!presetn)  // RL19
    1'b1 |=> alarm_los == $past(alarm_los_in) && alarm_lof == $past(alarm_lof_in))
    else $error("alarm output does not follow input");

endmodule

// ==== test/cpsd_strap_host.sv ====
// board-side strap model: bus select and shared pins, unused serial pins grounded
`timescale 1ns/10ps
module cpsd_strap_host (
  input  wire logic [1:0] mode,
  input  wire logic [7:0] want_addr,
  input  wire logic [7:0] want_ad,
  output logic      [1:0] bus_interface_select,
  output logic      [7:0] addr_in,
  output logic      [7:0] ad_in
);
  assign bus_interface_select = mode;
  // serial mode keeps only cpha, cpol and sck live; floating pins would pick up noise
  assign addr_in = (mode == 2'h2) ? (want_addr & 8'h30) : want_addr;
  assign ad_in   = (mode == 2'h2) ? (want_ad & 8'h04) : want_ad;
endmodule

// ==== test/tb_cpsd_top.sv ====
// self-checking bench for the control-port strap decoder
`timescale 1ns/10ps
module tb_cpsd_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ad_oe;
  logic        bus_timing_style_select, tx_clock_source_sel_lo, tx_clock_source_sel_hi;
  logic        external_tx_clock_in, tx_pll_clk, scaled_mclk, recovered_clk, port_rd_drive;
  logic        tx_gap_slot, rx_gap_slot, alarm_los_in, alarm_ais_in, alarm_lof_in;
  logic        mode_muxed, mode_nonmux, mode_serial, mode_hw, alt_timing_style;
  logic        address_latch_strobe, serial_sck, serial_cpha, serial_cpol;
  logic        tx_path_mode_sel_0, tx_alarm_signal_force, tx_termination_disable;
  logic        rx_termination_disable, e1_termination_select, pll_ref_from_ext;
  logic        tx_term_on, rx_term_on, tx_term_120, rx_term_120, tx_payload_active;
  logic        rx_payload_active, tx_clock_out_pin, pll_out_pin, rx_clock_out;
  logic        alarm_los, alarm_ais, alarm_lof;
  logic [1:0]  mode, bus_interface_select, prescaler_sel, rx_path_mode_sel;
  logic [2:0]  build_out_sel;
  logic [7:0]  paddr, ad_in, ad_out, addr_in, port_rd_data, par_addr, par_ad, want_addr, want_ad;
  logic [10:0] ctrl_m;
  logic [31:0] pwdata, prdata, r;
  integer      seed, error_cnt, check_count, cyc;

  cpsd_top        i_cpsd_top (.*);
  cpsd_strap_host i_cpsd_strap_host (.*);

  always #5 pclk = ~pclk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a hang counts against the run instead of stalling it
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic check_pins(input int m, input logic [31:0] v);
    logic [7:0] a, d;
    logic [3:0] ck;
    logic [1:0] tcs, rxm;
    logic       hw, par, sel, txp, rxp, txt, rxt, txm, big;
    a = v[7:0]; d = v[15:8]; hw = (m == 3); par = (m < 2);
    ck = {recovered_clk, scaled_mclk, tx_pll_clk, external_tx_clock_in};
    // outside hardware mode the control register image picks clocks, termination and payload
    tcs = hw ? {tx_clock_source_sel_hi, tx_clock_source_sel_lo} : ctrl_m[2:1];
    rxm = hw ? d[5:4] : ctrl_m[9:8];
    txm = hw ? a[5] : ctrl_m[10];
    big = hw ? a[0] : ctrl_m[7];
    sel = ck[tcs];
    txp = hw ? a[4:3] == 2'h3 : ctrl_m[4];
    rxp = txp && !rxm[1];
    txt = hw ? !d[6] : ctrl_m[5];
    rxt = hw ? !d[7] && !rxm[1] : ctrl_m[6];
    cmp({mode_hw, mode_serial, mode_nonmux, mode_muxed}, 64'h1 << m);
    cmp(alt_timing_style, par & bus_timing_style_select);
    cmp({address_latch_strobe, par_addr, par_ad}, par ? {m == 0 && a[7], a, d} : 17'h0);
    cmp({serial_sck, serial_cpha, serial_cpol}, m == 2 ? {d[2], a[4], a[5]} : 3'h0);
    cmp({build_out_sel, tx_path_mode_sel_0, tx_alarm_signal_force, prescaler_sel},
        hw ? {a[4:2], a[5], a[1], a[7:6]} : 7'h0);
    cmp({rx_path_mode_sel, tx_termination_disable, rx_termination_disable, e1_termination_select},
        hw ? {d[5:4], d[6], d[7], a[0]} : 5'h0);
    cmp(pll_ref_from_ext, hw | ctrl_m[0]);
    cmp({ad_out, ad_oe, alarm_los, alarm_ais, alarm_lof},
        {port_rd_data, par & port_rd_drive, alarm_los_in, alarm_ais_in, alarm_lof_in});
    cmp({tx_clock_out_pin, pll_out_pin},
        {sel & ~(txp & tx_gap_slot), (hw | ctrl_m[3]) ? sel : tx_pll_clk});
    cmp({tx_payload_active, rx_payload_active, rx_clock_out},
        {txp, rxp, recovered_clk & ~(rxp & rx_gap_slot)});
    cmp({tx_term_on, rx_term_on, tx_term_120, rx_term_120},
        {txt, rxt, txt & txm & big, rxt & (rxm == 2'h1) & big});
  endtask

  task automatic regs(input int m);
    logic [31:0] rd, w;
    logic        err;
    w = $random(seed);
    apb(cpsd_pkg::REG_STATUS, 1'b0, 32'h0, rd, err);
    if (m == 3) cmp({err, rd}, 64'h1_0000_0000);
    else cmp({err, rd[4:0]}, {1'b0, bus_timing_style_select & (m < 2), 4'h1 << m});
    apb(cpsd_pkg::REG_CTRL, 1'b1, w, rd, err);
    if (m != 3) ctrl_m = w[10:0];
    apb(cpsd_pkg::REG_CTRL, 1'b0, 32'h0, rd, err);
    cmp({err, rd}, m == 3 ? 64'h1_0000_0000 : {32'h0, ctrl_m});
    apb(cpsd_pkg::REG_STRAPS, 1'b0, 32'h0, rd, err);
    cmp({err, rd}, m == 3 ? 64'h1_0000_0000 : {m[1:0], want_ad & (m == 2 ? 8'h04 : 8'hff),
        want_addr & (m == 2 ? 8'h30 : 8'hff)});
    apb(8'h0c, 1'b1, w, rd, err);
    cmp({err, rd}, 64'h1_0000_0000);
  endtask

  initial begin
    seed = 32'hbfb19563;
    pclk = 0; presetn = 0; error_cnt = 0; check_count = 0; cyc = 0; ctrl_m = 11'h000;
    psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    mode = 2'h0; want_addr = 8'h00; want_ad = 8'h00; port_rd_data = 8'h00;
    {bus_timing_style_select, tx_clock_source_sel_hi, tx_clock_source_sel_lo,
     external_tx_clock_in, tx_pll_clk, scaled_mclk, recovered_clk, port_rd_drive,
     tx_gap_slot, rx_gap_slot, alarm_los_in, alarm_ais_in, alarm_lof_in} = 13'h0;
    repeat (20) @(posedge pclk);
    cmp({mode_muxed, pready, pslverr}, 3'h6);
    presetn <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      // every other hardware pass lands on a payload build-out code
      if (i % 8 == 3) r[4:3] = 2'h3;
      @(posedge pclk);
      mode <= i[1:0]; want_addr <= r[7:0]; want_ad <= r[15:8]; port_rd_data <= r[31:24];
      {bus_timing_style_select, tx_clock_source_sel_hi, tx_clock_source_sel_lo,
       external_tx_clock_in, tx_pll_clk, scaled_mclk, recovered_clk, port_rd_drive,
       tx_gap_slot, rx_gap_slot, alarm_los_in, alarm_ais_in, alarm_lof_in} <= r[28:16];
      repeat (6) @(posedge pclk);
      check_pins(i % 4, r);
      regs(i % 4);
    end
    summarize();
  end
endmodule
